/* hw/anpcs_pkg.sv */
package anpcs_pkg;
   // register addresses on the management interface
   localparam logic [4:0] ADDR_NPTX = 5'h07;
   localparam logic [4:0] ADDR_PCS = 5'h10;
   localparam logic [4:0] ADDR_ARB = 5'h11;
   localparam logic [4:0] ADDR_EXP = 5'h06;
   // next page transmit fields
   localparam int NP_MORE = 15;
   localparam int NP_ACK = 14;
   localparam int NP_FMT = 13;
   localparam int NP_COMPLY = 12;
   localparam int NP_TOGGLE = 11;
   localparam int NP_CODE_W = 11;
   localparam logic [15:0] NP_WR_MASK = 16'hb7ff;
   localparam logic [15:0] NP_RESET = 16'h0000;
   // pcs control fields
   localparam int PC_LOCKED = 15;
   localparam int PC_BYP_A = 5;
   localparam int PC_BYP_B = 4;
   localparam int PC_LOOPCFG = 3;
   localparam int PC_SCAN = 2;
   localparam int PC_FWRAP = 1;
   localparam int PC_FAST = 0;
   localparam logic [15:0] PC_WR_MASK = 16'h0fff;
   localparam logic [15:0] PC_RESET = 16'h0000;
   // expansion register page arrived bit
   localparam int EX_PAGE = 1;
   // link monitor timing at 40 mhz
   localparam int CLK_MHZ = 40;
   localparam int LM_NORMAL_US = 620;
   localparam int LM_FAST_US = 10;
   localparam int LM_NORMAL_CYC = LM_NORMAL_US * CLK_MHZ;
   localparam int LM_FAST_CYC = LM_FAST_US * CLK_MHZ;
   // apb register map of the station
   localparam logic [7:0] APB_CMD = 8'h00;
   localparam logic [7:0] APB_WDATA = 8'h04;
   localparam logic [7:0] APB_RDATA = 8'h08;
   localparam logic [7:0] APB_STAT = 8'h0c;
   localparam int CMD_GO = 31;
   localparam int CMD_WR = 30;
endpackage

/* hw/anpcs_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface anpcs_if;
   logic req;
   logic wr;
   logic [4:0] addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic ack;
   modport dev (input req, wr, addr, wdata, output rdata, ack);
   modport sta (output req, wr, addr, wdata, input rdata, ack);
endinterface
`default_nettype wire

/* hw/anpcs_regs.sv */
`timescale 1ns/10ps
`default_nettype none
module anpcs_regs (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // management side
   anpcs_if.dev mgmt,
   // autonegotiation engine
   input wire logic lcw_ack,
   input wire logic base_bit11,
   input wire logic first_np,
   input wire logic prev_ack,
   input wire logic page_rx,
   input wire logic [8:0] arb_states,
   input wire logic [2:0] arb_timers,
   input wire logic par_det_fault,
   output logic [15:0] np_word,
   output logic np_load,
   // pcs side
   input wire logic descr_locked,
   input wire logic bypass_sleep_a_in,
   input wire logic bypass_sleep_b_in,
   input wire logic fast_sim_input,
   output logic bypass_sleep_a,
   output logic bypass_sleep_b,
   output logic pcs_loop_full,
   output logic col_disable,
   output logic force_idle_tx,
   output logic scan_mode,
   output logic lm_tick
);
   logic [15:0] np_q, np_d;
   logic [15:0] pc_q, pc_d;
   logic tog_q, tog_d;
   logic pgrx_q, pgrx_d;
   logic [15:0] rd_q, rd_d;
   logic ack_q, ack_d;
   logic load_q, load_d;
   logic [15:0] lm_cnt_q, lm_cnt_d;
   logic tick_q, tick_d;
   logic [3:0] pcs_q, pcs_d;
   logic [15:0] arb_view;
   logic fast;

   //--------------------------------------------
   // register access and page bookkeeping
   //--------------------------------------------
   always_comb begin
      arb_view = {3'h0, arb_states[8], arb_timers, par_det_fault, arb_states[7:0]};
      np_d = np_q;
      pc_d = pc_q;
      tog_d = tog_q;
      pgrx_d = pgrx_q;
      rd_d = rd_q;
      ack_d = 1'b0;
      load_d = 1'b0;
      if (first_np) begin
         tog_d = ~base_bit11;
      end
      if (prev_ack) begin
         load_d = 1'b1;
         tog_d = ~tog_q;
      end
      if (mgmt.req && !ack_q) begin
         ack_d = 1'b1;
         if (mgmt.wr) begin
            if (mgmt.addr == anpcs_pkg::ADDR_NPTX) begin
               np_d = mgmt.wdata & anpcs_pkg::NP_WR_MASK;
            end
            if (mgmt.addr == anpcs_pkg::ADDR_PCS) begin
               pc_d = mgmt.wdata & anpcs_pkg::PC_WR_MASK;
            end
         end else begin
            case (mgmt.addr)
               anpcs_pkg::ADDR_NPTX: begin
                  rd_d = np_q;
                  rd_d[anpcs_pkg::NP_ACK] = lcw_ack;
                  rd_d[anpcs_pkg::NP_TOGGLE] = tog_q;
               end
               anpcs_pkg::ADDR_PCS: begin
                  rd_d = pc_q;
                  rd_d[anpcs_pkg::PC_LOCKED] = descr_locked;
               end
               anpcs_pkg::ADDR_ARB: rd_d = arb_view;
               anpcs_pkg::ADDR_EXP: begin
                  rd_d = 16'h0000;
                  rd_d[anpcs_pkg::EX_PAGE] = pgrx_q;
                  pgrx_d = 1'b0;
               end
               default: rd_d = 16'h0000;
            endcase
         end
      end
      if (page_rx) begin
         pgrx_d = 1'b1; // set wins over read clear
      end
   end

   //--------------------------------------------
   // pcs controls and link monitor timebase
   //--------------------------------------------
   always_comb begin
      fast = pc_q[anpcs_pkg::PC_FAST] | fast_sim_input;
      pcs_d[0] = pc_q[anpcs_pkg::PC_BYP_A] | bypass_sleep_a_in;
      pcs_d[1] = pc_q[anpcs_pkg::PC_BYP_B] | bypass_sleep_b_in;
      // either loop bit wraps without collision masking; only loop configure forces idle
      pcs_d[2] = pc_q[anpcs_pkg::PC_LOOPCFG] | pc_q[anpcs_pkg::PC_FWRAP];
      pcs_d[3] = ~pc_q[anpcs_pkg::PC_FWRAP] & ~pc_q[anpcs_pkg::PC_LOOPCFG];
      tick_d = 1'b0;
      lm_cnt_d = lm_cnt_q + 16'h0001;
      if (lm_cnt_q >= (fast ? 16'(anpcs_pkg::LM_FAST_CYC - 1)
                           : 16'(anpcs_pkg::LM_NORMAL_CYC - 1))) begin
         lm_cnt_d = 16'h0000;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         np_q <= anpcs_pkg::NP_RESET;
         pc_q <= anpcs_pkg::PC_RESET;
         tog_q <= 1'b0;
         pgrx_q <= 1'b0;
         rd_q <= 16'h0000;
         ack_q <= 1'b0;
         load_q <= 1'b0;
         lm_cnt_q <= 16'h0000;
         tick_q <= 1'b0;
         pcs_q <= 4'h8;
      end else begin
         np_q <= np_d;
         pc_q <= pc_d;
         tog_q <= tog_d;
         pgrx_q <= pgrx_d;
         rd_q <= rd_d;
         ack_q <= ack_d;
         load_q <= load_d;
         lm_cnt_q <= lm_cnt_d;
         tick_q <= tick_d;
         pcs_q <= pcs_d;
      end
   end

   //--------------------------------------------
   // outputs
   //--------------------------------------------
   // np_word carries the toggle already merged so the engine sends it as is
   logic [15:0] npw_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         npw_q <= 16'h0000;
      end else begin
         // next toggle is used so the word already matches while np_load is high
         npw_q <= {np_q[15], lcw_ack, np_q[13:12], tog_d, np_q[10:0]};
      end
   end
   assign np_word = npw_q;
   assign np_load = load_q;
   assign mgmt.rdata = rd_q;
   assign mgmt.ack = ack_q;
   assign bypass_sleep_a = pcs_q[0];
   assign bypass_sleep_b = pcs_q[1];
   assign pcs_loop_full = pcs_q[2];
   assign col_disable = pcs_q[3];
   assign force_idle_tx = pc_q[anpcs_pkg::PC_LOOPCFG];
   assign scan_mode = pc_q[anpcs_pkg::PC_SCAN];
   assign lm_tick = tick_q;
endmodule // anpcs_regs
`default_nettype wire

/* hw/anpcs_station.sv */
`timescale 1ns/10ps
`default_nettype none
module anpcs_station (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // management side
   anpcs_if.sta mgmt
);
   typedef enum logic [1:0] {ANPCS_IDLE, ANPCS_WAIT} anpcs_st_t;
   anpcs_st_t st_q, st_d;
   logic [31:0] cmd_q, cmd_d;
   logic [15:0] wd_q, wd_d;
   logic [15:0] rdat_q, rdat_d;
   logic busy_q, busy_d;
   logic [31:0] prd_q, prd_d;
   logic rdy_q, rdy_d;
   logic err_q, err_d;
   logic req_q, req_d;

   //--------------------------------------------
   // apb decode and command sequencing
   //--------------------------------------------
   always_comb begin
      st_d = st_q;
      cmd_d = cmd_q;
      wd_d = wd_q;
      rdat_d = rdat_q;
      busy_d = busy_q;
      prd_d = prd_q;
      rdy_d = 1'b0;
      err_d = 1'b0;
      req_d = req_q;
      if (psel && !penable) begin
         rdy_d = 1'b1;
         prd_d = 32'h0000_0000;
         case (paddr)
            anpcs_pkg::APB_CMD: prd_d = cmd_q;
            anpcs_pkg::APB_WDATA: prd_d = {16'h0000, wd_q};
            anpcs_pkg::APB_RDATA: prd_d = {16'h0000, rdat_q};
            anpcs_pkg::APB_STAT: prd_d = {31'h0, busy_q};
            default: err_d = 1'b1;
         endcase
      end
      // writes commit only at the edge that completes the access phase
      if (psel && penable && rdy_q) begin
         if (pwrite) begin
            if (paddr == anpcs_pkg::APB_WDATA) begin
               // reserved pcs bits are masked in anpcs_regs; debug pcs bits are software's job to zero
               wd_d = pwdata[15:0];
            end
            if (paddr == anpcs_pkg::APB_CMD && !busy_q && pwdata[anpcs_pkg::CMD_GO]) begin
               cmd_d = pwdata;
               busy_d = 1'b1;
            end
         end
      end
      case (st_q)
         ANPCS_IDLE: begin
            if (busy_q && !req_q) begin
               req_d = 1'b1;
               st_d = ANPCS_WAIT;
            end
         end
         ANPCS_WAIT: begin
            if (mgmt.ack) begin
               req_d = 1'b0;
               busy_d = 1'b0;
               if (!cmd_q[anpcs_pkg::CMD_WR]) begin
                  rdat_d = mgmt.rdata;
               end
               st_d = ANPCS_IDLE;
            end
         end
         default: st_d = ANPCS_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ANPCS_IDLE;
         cmd_q <= 32'h0000_0000;
         wd_q <= 16'h0000;
         rdat_q <= 16'h0000;
         busy_q <= 1'b0;
         prd_q <= 32'h0000_0000;
         rdy_q <= 1'b0;
         err_q <= 1'b0;
         req_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cmd_q <= cmd_d;
         wd_q <= wd_d;
         rdat_q <= rdat_d;
         busy_q <= busy_d;
         prd_q <= prd_d;
         rdy_q <= rdy_d;
         err_q <= err_d;
         req_q <= req_d;
      end
   end

   assign prdata = prd_q;
   assign pready = rdy_q;
   assign pslverr = err_q;
   assign mgmt.req = req_q;
   assign mgmt.wr = cmd_q[anpcs_pkg::CMD_WR];
   assign mgmt.addr = cmd_q[4:0];
   assign mgmt.wdata = wd_q;
endmodule // anpcs_station
`default_nettype wire

/* test/anpcs_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module anpcs_asserts (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // management link
   input wire logic req,
   input wire logic wr,
   input wire logic [4:0] addr,
   input wire logic [15:0] wdata,
   input wire logic [15:0] rdata,
   input wire logic ack
);
   // ------
   // shadow
   // ------
   logic [15:0] np_q;
   logic [15:0] np_d;
   logic [15:0] pc_q;
   logic [15:0] pc_d;
   logic rd7;
   logic rd16;
   logic rd17;
   assign rd7 = ack & !wr & addr == anpcs_pkg::ADDR_NPTX;
   assign rd16 = ack & !wr & addr == anpcs_pkg::ADDR_PCS;
   assign rd17 = ack & !wr & addr == anpcs_pkg::ADDR_ARB;
   // last written words let reads be judged without looking inside
   always_comb begin
      np_d = np_q;
      pc_d = pc_q;
      if (ack & wr & addr == anpcs_pkg::ADDR_NPTX)
         np_d = wdata;
      if (ack & wr & addr == anpcs_pkg::ADDR_PCS)
         pc_d = wdata;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         np_q <= 16'h0000;
         pc_q <= 16'h0000;
      end else begin
         np_q <= np_d;
         pc_q <= pc_d;
      end
   end
   // ------
   // checks
   // ------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_np_more_bit: assert property (rd7 |-> rdata[15] == np_q[15])
      else $error("more bit differs");
   a_np_fmt_bit: assert property (rd7 |-> rdata[13] == np_q[13])
      else $error("format bit differs");
   a_np_comply_bit: assert property (rd7 |-> rdata[12] == np_q[12])
      else $error("comply bit differs");
   a_np_code_field: assert property (rd7 |-> rdata[10:0] == np_q[10:0])
      else $error("code field differs");
   a_pcs_bypass_bits: assert property (rd16 |-> rdata[5:4] == pc_q[5:4])
      else $error("bypass bits differ");
   a_pcs_loop_bits: assert property (rd16 |-> rdata[3:1] == pc_q[3:1])
      else $error("loop bits differ");
   a_pcs_fast_bit: assert property (rd16 |-> rdata[0] == pc_q[0])
      else $error("fast bit differs");
   a_pcs_resv_zero: assert property (rd16 |-> rdata[14:12] == 3'h0)
      else $error("reserved pcs bits set");
   a_arb_top_zero: assert property (rd17 |-> rdata[15:13] == 3'h0)
      else $error("monitor top bits set");
   a_ack_one_pulse: assert property ($rose(req) |=> ack ##1 !ack)
      else $error("ack not one cycle after request");
   cover property (rd7);
   cover property (rd16 && rdata[3]);
   cover property (rd17 && rdata[8]);
endmodule // anpcs_asserts
`default_nettype wire

/* test/test_anpcs_regs.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
 $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_anpcs_regs;
   // ------
   // wiring
   // ------
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic lcw_ack, base_bit11, first_np, prev_ack, page_rx, par_det_fault, np_load;
   logic [8:0] arb_states;
   logic [2:0] arb_timers;
   logic [15:0] np_word, pv;
   logic descr_locked, bypass_sleep_a_in, bypass_sleep_b_in, fast_sim_input, lm_tick;
   logic bypass_sleep_a, bypass_sleep_b, pcs_loop_full, col_disable, force_idle_tx, scan_mode;
   int bad_count = 0;
   int total_checks = 0;
   int n;
   anpcs_if u_anpcs_if ();
   anpcs_station u_anpcs_station (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .mgmt(u_anpcs_if.sta));
   anpcs_regs u_anpcs_regs (.pclk, .presetn, .mgmt(u_anpcs_if.dev), .lcw_ack, .base_bit11,
      .first_np, .prev_ack, .page_rx, .arb_states, .arb_timers, .par_det_fault, .np_word,
      .np_load, .descr_locked, .bypass_sleep_a_in, .bypass_sleep_b_in, .fast_sim_input,
      .bypass_sleep_a, .bypass_sleep_b, .pcs_loop_full, .col_disable, .force_idle_tx,
      .scan_mode, .lm_tick);
   anpcs_asserts u_anpcs_asserts (.pclk, .presetn, .req(u_anpcs_if.req),
      .wr(u_anpcs_if.wr), .addr(u_anpcs_if.addr), .wdata(u_anpcs_if.wdata),
      .rdata(u_anpcs_if.rdata), .ack(u_anpcs_if.ack));
   // ------
   // tasks
   // ------
   // an idle cycle after each transfer keeps strobes from being set twice in a step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic mg(input logic w, input logic [4:0] a, input logic [15:0] d);
      int k;
      k = 0;
      apb(1'b1, anpcs_pkg::APB_WDATA, {16'h0000, d});
      apb(1'b1, anpcs_pkg::APB_CMD, {1'b1, w, 25'h0, a});
      do begin
         apb(1'b0, anpcs_pkg::APB_STAT, 32'h0);
         k++;
      end while (rd[0] !== 1'b0 && k < 50);
      if (rd[0] !== 1'b0) bad_count++;
      apb(1'b0, anpcs_pkg::APB_RDATA, 32'h0);
   endtask
   // waits for one tick, then counts the full period to the next
   task automatic meas();
      while (lm_tick !== 1'b1) @(posedge pclk);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (lm_tick !== 1'b1);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   initial begin
      repeat (90000) @(posedge pclk);
      bad_count++;
      end_sim();
   end
   // ------
   // tests
   // ------
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, lcw_ack, base_bit11, first_np} = '0;
      {prev_ack, page_rx, arb_states, arb_timers, par_det_fault, descr_locked} = '0;
      {bypass_sleep_a_in, bypass_sleep_b_in, fast_sim_input} = '0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      mg(1'b0, anpcs_pkg::ADDR_NPTX, 16'h0);
      `CHK("np reset", 32'h0, rd)
      for (int b = 0; b < 2; b++) begin
         lcw_ack <= b[0];
         base_bit11 <= b[0];
         first_np <= 1'b1;
         mg(1'b1, anpcs_pkg::ADDR_NPTX, 16'hffff);
         first_np <= 1'b0;
         mg(1'b0, anpcs_pkg::ADDR_NPTX, 16'h0);
         `CHK("np first", {16'h0, 1'b1, b[0], 2'b11, ~b[0], 11'h7ff}, rd)
         prev_ack <= 1'b1;
         @(posedge pclk);
         prev_ack <= 1'b0;
         for (int i = 0; i < 8 && np_load !== 1'b1; i++) @(posedge pclk);
         `CHK("np sent", {1'b1, b[0], 2'b11, b[0], 11'h7ff}, np_word)
         mg(1'b1, anpcs_pkg::ADDR_NPTX, 16'h2abc);
         mg(1'b0, anpcs_pkg::ADDR_NPTX, 16'h0);
         `CHK("np word", {16'h0, 1'b0, b[0], 2'b10, b[0], 11'h2bc}, rd)
      end
      $display("next page test done");
      for (int k = 0; k < 4; k++) begin
         // every pairing of loop configure and forced wrap, debug bits left zero
         pv = {k[0] ^ k[1], 9'h0, k[0], ~k[0], k[1], k[1] ^ k[0], k[0], ~k[1]};
         descr_locked <= pv[15];
         mg(1'b1, anpcs_pkg::ADDR_PCS, {10'h0, pv[5:0]});
         mg(1'b0, anpcs_pkg::ADDR_PCS, 16'h0);
         `CHK("pcs read", {16'h0, pv[15], 9'h0, pv[5:0]}, rd)
         `CHK("bypass scan", {pv[5], pv[4], pv[2]}, {bypass_sleep_a, bypass_sleep_b, scan_mode})
         `CHK("full loop", pv[3] | pv[1], pcs_loop_full)
         `CHK("col off", ~pv[3] & ~pv[1], col_disable)
         `CHK("idle", pv[3], force_idle_tx)
      end
      mg(1'b1, anpcs_pkg::ADDR_PCS, 16'h0);
      {bypass_sleep_a_in, bypass_sleep_b_in} <= 2'b10;
      repeat (3) @(posedge pclk);
      `CHK("bypass a in", 2'b10, {bypass_sleep_a, bypass_sleep_b})
      {bypass_sleep_a_in, bypass_sleep_b_in} <= 2'b01;
      repeat (3) @(posedge pclk);
      `CHK("bypass b in", 2'b01, {bypass_sleep_a, bypass_sleep_b})
      fast_sim_input <= 1'b1;
      meas();
      meas();
      `CHK("fast input", anpcs_pkg::LM_FAST_CYC, n)
      fast_sim_input <= 1'b0;
      mg(1'b1, anpcs_pkg::ADDR_PCS, 16'h0001);
      meas();
      meas();
      `CHK("fast bit", anpcs_pkg::LM_FAST_CYC, n)
      mg(1'b1, anpcs_pkg::ADDR_PCS, 16'h0);
      meas();
      meas();
      `CHK("slow", anpcs_pkg::LM_NORMAL_CYC, n)
      $display("pcs test done");
      for (int k = 0; k < 2; k++) begin
         arb_states <= 9'h05a ^ {9{k[0]}};
         arb_timers <= 3'b010 ^ {3{k[0]}};
         par_det_fault <= k[0];
         mg(1'b0, anpcs_pkg::ADDR_ARB, 16'h0);
         `CHK("monitor", {19'h0, k[0], 3'b010 ^ {3{k[0]}}, k[0], 8'h5a ^ {8{k[0]}}}, rd)
      end
      page_rx <= 1'b1;
      @(posedge pclk);
      page_rx <= 1'b0;
      mg(1'b0, anpcs_pkg::ADDR_EXP, 16'h0);
      `CHK("page set", 1'b1, rd[anpcs_pkg::EX_PAGE])
      mg(1'b0, anpcs_pkg::ADDR_EXP, 16'h0);
      `CHK("page clear", 1'b0, rd[anpcs_pkg::EX_PAGE])
      apb(1'b0, 8'h40, 32'h0);
      `CHK("unmapped", 1'b1, er)
      $display("monitor test done");
      end_sim();
   end
endmodule // test_anpcs_regs
`default_nettype wire
